// File: hdl/tlbex_mem.sv
`timescale 1ns/1ns
module tlbex_mem
   import tlbex_pkg::*;
(
   input wire logic clk,
   input wire logic we,
   input wire logic [IDX_W-1:0] waddr,
   input wire logic [ENTRY_W-1:0] wdata,
   input wire logic [IDX_W-1:0] raddr,
   output logic [ENTRY_W-1:0] rdata
);
   logic [ENTRY_W-1:0] mem [ENTRIES];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      rdata <= mem[raddr];
   end
endmodule : tlbex_mem

// File: hdl/tlbex_pkg.sv
package tlbex_pkg;

   localparam int unsigned ENTRIES = 8;
   localparam int unsigned IDX_W = 3;
   localparam int unsigned TAG_W = 8;
   localparam int unsigned PPN_W = 27;
   localparam int unsigned PFN_W = 20;
   localparam int unsigned CACHE_W = 3;
   localparam int unsigned MASK_W = 12;
   localparam int unsigned ENTRY_W = TAG_W + 1 + PPN_W + MASK_W + PFN_W + CACHE_W + 2;

   // coprocessor-zero register numbers
   localparam logic [4:0] REG_PTP = 5'h04;
   localparam logic [4:0] REG_FVA = 5'h08;
   localparam logic [4:0] REG_COUNT = 5'h09;
   localparam logic [4:0] REG_COMPARE = 5'h0b;
   localparam logic [4:0] REG_STATUS = 5'h0c;
   localparam logic [4:0] REG_CAUSE = 5'h0d;
   localparam logic [4:0] REG_RESTART = 5'h0e;
   localparam logic [4:0] REG_WATCH_LO = 5'h12;
   localparam logic [4:0] REG_WATCH_HI = 5'h13;
   localparam logic [4:0] REG_XPTR = 5'h14;
   localparam logic [4:0] REG_PARITY = 5'h1a;
   localparam logic [4:0] REG_CACHE_FAULT = 5'h1b;
   localparam logic [4:0] REG_ERR_RESTART = 5'h1e;
   // block-local registers
   localparam logic [4:0] REG_ENTRY_HIGH = 5'h0a;
   localparam logic [4:0] REG_INDEX = 5'h00;
   localparam logic [4:0] REG_ENTRY_LOW = 5'h02;

   // page-table pointer layout
   localparam int unsigned PTP_FPP_LSB = 4;
   localparam int unsigned PTP_FPP_W = 19;
   localparam int unsigned PTP_BASE_LSB = 23;
   localparam int unsigned PTP_BASE_W = 9;
   localparam int unsigned VA_FPP_LSB = 13;
   localparam logic [31:0] PTP_RESET = 32'h0000_0000;

   // status layout (block-local)
   localparam int unsigned ST_IE = 0;
   localparam int unsigned ST_EXL = 1;
   localparam int unsigned ST_ERL = 2;
   localparam int unsigned ST_MODE_LSB = 3;
   localparam int unsigned ST_IM_LSB = 8;
   localparam int unsigned ST_X64 = 16;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0004;

   localparam logic [2:0] CACHE_UNCACHED = 3'h2;
   localparam logic [63:0] HANDLER_VEC = 64'h0000_0000_8000_0180;
   localparam logic [1:0] MODE_KERNEL = 2'h0;

   typedef enum logic [1:0] {
      TLBEX_OP_PROBE = 2'b00,
      TLBEX_OP_READ = 2'b01,
      TLBEX_OP_WR_IDX = 2'b10,
      TLBEX_OP_WR_RND = 2'b11
   } tlbex_op_t;

   typedef enum logic [2:0] {
      TLBEX_RES_HIT = 3'b000,
      TLBEX_RES_REFILL = 3'b001,
      TLBEX_RES_INVALID = 3'b010,
      TLBEX_RES_MODIFY = 3'b011,
      TLBEX_RES_UNCACHED = 3'b100
   } tlbex_res_t;

   typedef struct packed {
      logic [TAG_W-1:0] tag;
      logic global_f;
      logic [PPN_W-1:0] ppn;
      logic [MASK_W-1:0] mask;
      logic [PFN_W-1:0] pfn;
      logic [CACHE_W-1:0] cache;
      logic dirty;
      logic valid;
   } tlbex_entry_t;

   typedef struct packed {
      logic valid;
      logic [63:0] pc;
      logic in_delay;
      logic [63:0] branch_pc;
      logic [2:0] fault;
   } tlbex_stage_t;

endpackage : tlbex_pkg

// File: hdl/tlbex_top.sv
`timescale 1ns/1ns
module tlbex_top
   import tlbex_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic xlat_req,
   input wire logic [63:0] xlat_va,
   input wire logic xlat_store,
   output logic xlat_done,
   output tlbex_res_t xlat_res,
   output logic [31:0] xlat_pa,
   output logic xlat_uncached,
   input wire logic op_req,
   input wire tlbex_op_t op_code,
   output logic op_done,
   input wire tlbex_stage_t stage_old,
   input wire tlbex_stage_t stage_young,
   input wire logic eret,
   input wire logic [7:0] irq,
   output logic flush_young,
   output logic redirect,
   output logic [63:0] redirect_pc,
   output logic irq_take,
   output logic kernel_mode,
   input wire logic src_busy,
   input wire logic [4:0] src_a,
   input wire logic [4:0] src_b,
   input wire logic [4:0] dst_pend,
   output logic stall
);
   import tlbex_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [31:0] ptp_q;
   logic [31:0] status_q;
   logic [63:0] restart_q;
   logic [63:0] fva_q;
   logic [TAG_W+PPN_W-1:0] ehi_q;
   logic [IDX_W-1:0] index_q;
   logic probe_miss_q;
   logic [IDX_W-1:0] rnd_q;
   tlbex_entry_t ent_wr_q;
   tlbex_entry_t ent [ENTRIES];
   logic [ENTRY_W-1:0] mem_rdata;
   logic mem_we;
   logic [IDX_W-1:0] mem_waddr;

   function automatic logic ent_match(input tlbex_entry_t e, input logic [63:0] va,
                                      input logic [TAG_W-1:0] tag, input logic x64);
      logic [PPN_W-1:0] vpn;
      logic [PPN_W-1:0] msk;
      vpn = va[39:13];
      // upper 8 bits of the pair number only count in 64-bit mode
      msk = {{(PPN_W-19){x64}}, 7'h7f, ~e.mask};
      ent_match = ((vpn & msk) == (e.ppn & msk)) && (e.global_f || e.tag == tag);
   endfunction : ent_match

   ////////////////////////////////////////////////////////////////////////
   // match array
   logic [ENTRIES-1:0] hit_vec;
   logic [IDX_W-1:0] hit_idx;
   logic [ENTRIES-1:0] probe_vec;
   logic [IDX_W-1:0] probe_idx;

   always_comb
   begin
      hit_idx = '0;
      probe_idx = '0;
      for (int i = 0; i < ENTRIES; i++)
      begin
         hit_vec[i] = ent_match(ent[i], xlat_va, ehi_q[TAG_W+PPN_W-1:PPN_W], status_q[ST_X64]);
         probe_vec[i] = ent_match(ent[i], {24'h0, ehi_q[PPN_W-1:0], 13'h0},
                                  ehi_q[TAG_W+PPN_W-1:PPN_W], 1'b1);
         if (hit_vec[i])
         begin
            hit_idx = IDX_W'(i);
         end
         if (probe_vec[i])
         begin
            probe_idx = IDX_W'(i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // translation result
   tlbex_entry_t he;
   tlbex_res_t res_d;
   assign he = ent[hit_idx];

   always_comb
   begin
      if (hit_vec == '0)
      begin
         res_d = TLBEX_RES_REFILL;
      end
      else if (!he.valid)
      begin
         res_d = TLBEX_RES_INVALID;
      end
      else if (xlat_store && !he.dirty)
      begin
         res_d = TLBEX_RES_MODIFY;
      end
      else if (he.cache == CACHE_UNCACHED)
      begin
         res_d = TLBEX_RES_UNCACHED;
      end
      else
      begin
         res_d = TLBEX_RES_HIT;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         xlat_done <= 1'b0;
         xlat_res <= TLBEX_RES_HIT;
         xlat_pa <= '0;
         xlat_uncached <= 1'b0;
      end
      else
      begin
         xlat_done <= xlat_req;
         if (xlat_req)
         begin
            xlat_res <= res_d;
            xlat_pa <= {he.pfn, xlat_va[11:0]};
            xlat_uncached <= (res_d == TLBEX_RES_UNCACHED);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // buffer operations; a shadow copy feeds the parallel compare
   logic op_rd_q;
   tlbex_entry_t rd_ent;
   tlbex_entry_t ent_wdata;
   assign rd_ent = tlbex_entry_t'(mem_rdata);

   always_comb
   begin
      ent_wdata = ent_wr_q;
      // a written entry takes page pair and tag from entry-high, as a probe does
      ent_wdata.tag = ehi_q[TAG_W+PPN_W-1:PPN_W];
      ent_wdata.ppn = ehi_q[PPN_W-1:0];
   end

   assign mem_we = op_req && (op_code == TLBEX_OP_WR_IDX || op_code == TLBEX_OP_WR_RND);
   assign mem_waddr = (op_code == TLBEX_OP_WR_RND) ? rnd_q : index_q;

   tlbex_mem u_mem (
      .clk(clk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(ENTRY_W'(ent_wdata)),
      .raddr(index_q),
      .rdata(mem_rdata)
   );

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < ENTRIES; i++)
         begin
            ent[i] <= '0;
         end
      end
      else if (mem_we)
      begin
         ent[mem_waddr] <= ent_wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         index_q <= '0;
         probe_miss_q <= 1'b0;
         rnd_q <= '1;
         op_rd_q <= 1'b0;
         op_done <= 1'b0;
         ent_wr_q <= '0;
      end
      else
      begin
         rnd_q <= rnd_q - 1'b1;
         op_rd_q <= op_req && op_code == TLBEX_OP_READ;
         op_done <= op_req;
         if (op_req && op_code == TLBEX_OP_PROBE)
         begin
            index_q <= probe_idx;
            probe_miss_q <= (probe_vec == '0);
         end
         else if (reg_wr && reg_addr == REG_INDEX)
         begin
            index_q <= reg_wdata[IDX_W-1:0];
         end
         if (op_rd_q)
         begin
            ent_wr_q <= tlbex_entry_t'(mem_rdata);
         end
         else if (reg_wr && reg_addr == REG_ENTRY_HIGH)
         begin
            ent_wr_q.tag <= reg_wdata[31:24];
            ent_wr_q.global_f <= reg_wdata[23];
            ent_wr_q.cache <= reg_wdata[22:20];
            ent_wr_q.dirty <= reg_wdata[19];
            ent_wr_q.valid <= reg_wdata[18];
            ent_wr_q.mask <= reg_wdata[MASK_W-1:0];
         end
         else if (reg_wr && reg_addr == REG_ENTRY_LOW)
         begin
            // frame number for the physical address
            ent_wr_q.pfn <= reg_wdata[PFN_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // exception selection
   logic exception_level_flag;
   logic error_level_flag;
   logic take_old;
   logic take_young;
   logic irq_ok;
   tlbex_stage_t ex;
   assign exception_level_flag = status_q[ST_EXL];
   assign error_level_flag = status_q[ST_ERL];
   assign irq_ok = status_q[ST_IE] && !exception_level_flag && !error_level_flag && |(irq & status_q[ST_IM_LSB +: 8]);
   assign take_old = stage_old.valid && stage_old.fault != 3'h0;
   assign take_young = !take_old && stage_young.valid && stage_young.fault != 3'h0;
   // interrupts restart at the older instruction unless the younger stage faults in the same cycle
   assign ex = take_young ? stage_young : stage_old;

   logic exc;
   assign exc = take_old || take_young || (irq_ok && stage_old.valid);

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         flush_young <= 1'b0;
         redirect <= 1'b0;
         redirect_pc <= '0;
         irq_take <= 1'b0;
      end
      else
      begin
         flush_young <= exc;
         redirect <= exc || eret;
         redirect_pc <= exc ? HANDLER_VEC : restart_q;
         irq_take <= irq_ok && stage_old.valid && !take_old;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         restart_q <= '0;
      end
      else if (exc && !exception_level_flag)
      begin
         restart_q <= ex.in_delay ? ex.branch_pc : ex.pc;
      end
      else if (reg_wr && reg_addr == REG_RESTART)
      begin
         restart_q <= {32'h0, reg_wdata};
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         status_q <= STATUS_RESET;
      end
      else if (exc)
      begin
         status_q[ST_EXL] <= 1'b1;
      end
      else if (eret)
      begin
         status_q[ST_EXL] <= 1'b0;
      end
      else if (reg_wr && reg_addr == REG_STATUS)
      begin
         status_q <= reg_wdata & 32'h0001_ff1f;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         kernel_mode <= 1'b1;
      end
      else
      begin
         kernel_mode <= exception_level_flag || error_level_flag || exc || status_q[ST_MODE_LSB +: 2] == MODE_KERNEL;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // translation fault capture; hardware capture wins over software write
   logic xfault;
   assign xfault = xlat_req && res_d != TLBEX_RES_HIT && res_d != TLBEX_RES_UNCACHED;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ptp_q <= PTP_RESET;
         fva_q <= '0;
         ehi_q <= '0;
      end
      else
      begin
         if (xfault)
         begin
            ptp_q[PTP_FPP_LSB +: PTP_FPP_W] <= xlat_va[VA_FPP_LSB +: PTP_FPP_W];
            fva_q <= xlat_va;
            ehi_q[PPN_W-1:0] <= xlat_va[39:13];
         end
         else if (reg_wr && reg_addr == REG_ENTRY_HIGH)
         begin
            ehi_q <= {reg_wdata[31:24], 8'h0, reg_wdata[31:13]};
         end
         else if (op_rd_q)
         begin
            ehi_q <= {rd_ent.tag, rd_ent.ppn};
         end
         if (reg_wr && reg_addr == REG_PTP)
         begin
            ptp_q[PTP_BASE_LSB +: PTP_BASE_W] <= reg_wdata[PTP_BASE_LSB +: PTP_BASE_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read port
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         reg_rdata <= '0;
      end
      else if (reg_rd)
      begin
         unique case (reg_addr)
            REG_PTP: reg_rdata <= ptp_q;
            REG_FVA: reg_rdata <= fva_q[31:0];
            REG_STATUS: reg_rdata <= status_q;
            REG_RESTART: reg_rdata <= restart_q[31:0];
            REG_INDEX: reg_rdata <= {probe_miss_q, 28'h0, index_q};
            REG_ENTRY_HIGH: reg_rdata <= {ehi_q[TAG_W+PPN_W-1:PPN_W], 5'h0, ehi_q[18:0]};
            default: reg_rdata <= '0;
         endcase
      end
      else
      begin
         reg_rdata <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // general-register interlock; coprocessor state has none, software pads
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         stall <= 1'b0;
      end
      else
      begin
         stall <= src_busy && dst_pend != 5'h0 && (src_a == dst_pend || src_b == dst_pend);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_refill;
      @(posedge clk) disable iff (!rst_b)
      (xlat_req && hit_vec == '0) |=> xlat_done && xlat_res == TLBEX_RES_REFILL;
   endproperty
   a_refill: assert property (p_refill) else $error("miss not refill");

   property p_fpp;
      @(posedge clk) disable iff (!rst_b)
      xfault |=> ptp_q[22:4] == $past(xlat_va[31:13]) && ptp_q[3:0] == 4'h0;
   endproperty
   a_fpp: assert property (p_fpp) else $error("page pair not captured");

   property p_uncached;
      @(posedge clk) disable iff (!rst_b)
      (xlat_req && res_d == TLBEX_RES_UNCACHED) |=> xlat_uncached;
   endproperty
   a_uncached: assert property (p_uncached) else $error("uncached not flagged");

   sequence s_exc;
      exc && !exception_level_flag;
   endsequence
   property p_enter;
      @(posedge clk) disable iff (!rst_b)
      s_exc |=> status_q[ST_EXL] && redirect && redirect_pc == HANDLER_VEC && kernel_mode;
   endproperty
   a_enter: assert property (p_enter) else $error("exception entry wrong");

   property p_restart;
      @(posedge clk) disable iff (!rst_b)
      s_exc |=> restart_q == ($past(ex.in_delay) ? $past(ex.branch_pc) : $past(ex.pc));
   endproperty
   a_restart: assert property (p_restart) else $error("restart address wrong");

   property p_irq;
      @(posedge clk) disable iff (!rst_b)
      irq_take |-> $past(status_q[ST_IE]) && !$past(exception_level_flag) && !$past(error_level_flag);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt taken while gated");

   property p_eret;
      @(posedge clk) disable iff (!rst_b)
      (eret && !exc) |=> !status_q[ST_EXL];
   endproperty
   a_eret: assert property (p_eret) else $error("return kept level");

   property p_order;
      @(posedge clk) disable iff (!rst_b)
      (take_old && !exception_level_flag) |=> restart_q == ($past(stage_old.in_delay) ?
                                           $past(stage_old.branch_pc) : $past(stage_old.pc));
   endproperty
   a_order: assert property (p_order) else $error("younger fault taken first");
endmodule : tlbex_top

// File: tb/tb_tlbex_top.sv
`timescale 1ns/1ns
module tb_tlbex_top
   import tlbex_pkg::*;
;
   logic clk, rst_b, reg_wr, reg_rd, xlat_req, xlat_store, xlat_done, xlat_uncached;
   logic op_req, op_done, eret, flush_young, redirect, irq_take, kernel_mode;
   logic src_busy, stall;
   logic [4:0] reg_addr, src_a, src_b, dst_pend;
   logic [31:0] reg_wdata, reg_rdata, xlat_pa, d;
   logic [63:0] xlat_va, redirect_pc;
   logic [7:0] irq;
   tlbex_res_t xlat_res;
   tlbex_op_t op_code;
   tlbex_stage_t stage_old, stage_young;
   int err_total, tests_run, n;
   logic [5:0] fl [8] = '{6'h0f, 6'h0e, 6'h0d, 6'h0b, 6'h2f, 6'h0f, 6'h0f, 6'h0f};
   tlbex_res_t er [8] = '{TLBEX_RES_HIT, TLBEX_RES_INVALID, TLBEX_RES_HIT,
      TLBEX_RES_UNCACHED, TLBEX_RES_HIT, TLBEX_RES_HIT, TLBEX_RES_HIT, TLBEX_RES_HIT};
   logic [4:0] unm [9] = '{5'h09, 5'h0b, 5'h0d, 5'h12, 5'h13, 5'h14, 5'h1a, 5'h1b, 5'h1e};

   tlbex_top DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xlat_req(xlat_req),
      .xlat_va(xlat_va), .xlat_store(xlat_store), .xlat_done(xlat_done),
      .xlat_res(xlat_res), .xlat_pa(xlat_pa), .xlat_uncached(xlat_uncached),
      .op_req(op_req), .op_code(op_code), .op_done(op_done), .stage_old(stage_old),
      .stage_young(stage_young), .eret(eret), .irq(irq), .flush_young(flush_young),
      .redirect(redirect), .redirect_pc(redirect_pc), .irq_take(irq_take),
      .kernel_mode(kernel_mode), .src_busy(src_busy), .src_a(src_a), .src_b(src_b),
      .dst_pend(dst_pend), .stall(stall));
   tlbex_pipe_model PIPE (.clk(clk), .stage_old(stage_old), .stage_young(stage_young),
      .eret(eret), .irq(irq), .src_busy(src_busy), .src_a(src_a), .src_b(src_b),
      .dst_pend(dst_pend));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~v;
   endtask : wr
   task automatic rd(input logic [4:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   task automatic op(input tlbex_op_t c);
      @(posedge clk);
      op_req <= 1'b1;
      op_code <= c;
      @(posedge clk);
      op_req <= 1'b0;
      #1;
      chk("op_done", 1, op_done);
      // the buffer is not interlocked, so let the write settle
      repeat (2) @(posedge clk);
   endtask : op
   task automatic xl(input logic [63:0] va, input logic st, input tlbex_res_t r);
      @(posedge clk);
      xlat_req <= 1'b1;
      xlat_va <= va;
      xlat_store <= st;
      @(posedge clk);
      xlat_req <= 1'b0;
      xlat_va <= ~va;
      #1;
      chk("xlat_done", 1, xlat_done);
      chk("xlat_res", r, xlat_res);
   endtask : xl
   task automatic stl(input logic b, input logic [4:0] a, input logic [4:0] c,
         input logic e);
      PIPE.src(b, a, c);
      repeat (2) @(posedge clk);
      #1;
      chk("stall", e, stall);
   endtask : stl
   task automatic irq_count(input int lim);
      n = 0;
      repeat (lim)
      begin
         @(posedge clk);
         #1;
         if (irq_take === 1'b1)
            n++;
      end
   endtask : irq_count
   // entry k: tag 0x10+k, flags from fl, page pair unique by k
   function automatic logic [31:0] ent(input int k);
      return {8'(8'h10 + k), fl[k], 5'(k), 13'h0000};
   endfunction : ent
   function automatic logic [63:0] vak(input int k);
      logic [31:0] e;
      e = ent(k);
      return {32'h0, e[31:13], 13'h0abc};
   endfunction : vak
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst_b, reg_wr, reg_rd, xlat_req, xlat_store, op_req, err_total, tests_run} = '0;
      {reg_addr, reg_wdata, xlat_va, d} = '0;
      op_code = TLBEX_OP_PROBE;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rd(REG_STATUS);
      chk("status_rst", 32'h4, d);
      chk("kernel_rst", 1, kernel_mode);
      rd(REG_PTP);
      chk("ptp_rst", 32'h0, d);
      wr(REG_COUNT, 32'h1234_5678);
      foreach (unm[i])
      begin
         rd(unm[i]);
         chk("unmapped", 0, d);
      end
      wr(REG_PTP, 32'hffff_ffff);
      rd(REG_PTP);
      chk("ptp_rw", 32'hff80_0000, d & 32'hff80_000f);
      for (int k = 0; k < 8; k++)
      begin
         wr(REG_INDEX, 32'(k));
         wr(REG_ENTRY_HIGH, ent(k));
         wr(REG_ENTRY_LOW, 32'h0000_0100 + 32'(k));
         op(TLBEX_OP_WR_IDX);
      end
      for (int k = 0; k < 8; k++)
      begin
         wr(REG_ENTRY_HIGH, ent(k));
         xl(vak(k), 1'b0, er[k]);
         chk("pa", 64'h0010_0abc + 64'(k) * 64'h1000, xlat_pa);
         chk("uncached", k == 3, xlat_uncached);
      end
      wr(REG_ENTRY_HIGH, ent(2));
      xl(vak(2), 1'b1, TLBEX_RES_MODIFY);
      wr(REG_ENTRY_HIGH, ent(4) ^ 32'h4500_0000);
      xl(vak(4), 1'b0, TLBEX_RES_HIT);
      wr(REG_ENTRY_HIGH, ent(0) ^ 32'h4500_0000);
      xl(vak(0), 1'b0, TLBEX_RES_REFILL);
      rd(REG_PTP);
      chk("ptp_fault", {9'h1ff, 19'(ent(0) >> 13), 4'h0}, d);
      rd(REG_FVA);
      chk("fault_va", vak(0) & 64'hffff_ffff, d);
      wr(REG_STATUS, 32'h0001_0000);
      wr(REG_ENTRY_HIGH, ent(5));
      xl(vak(5), 1'b0, TLBEX_RES_HIT);
      xl(vak(5) | 64'h0000_0010_0000_0000, 1'b0, TLBEX_RES_REFILL);
      // the miss reloaded entry-high, so put the probed page pair back
      wr(REG_ENTRY_HIGH, ent(5));
      op(TLBEX_OP_PROBE);
      rd(REG_INDEX);
      chk("probe_hit", 32'h5, d);
      wr(REG_ENTRY_HIGH, ent(5) ^ 32'h4500_0000);
      op(TLBEX_OP_PROBE);
      rd(REG_INDEX);
      chk("probe_miss", 32'h8000_0000, d & 32'h8000_0000);
      wr(REG_INDEX, 32'h4);
      op(TLBEX_OP_READ);
      rd(REG_ENTRY_HIGH);
      chk("read_tag", 32'h14, d >> 24);
      op(TLBEX_OP_WR_RND);
      wr(REG_STATUS, 32'h0000_0010);
      repeat (2) @(posedge clk);
      chk("user_mode", 0, kernel_mode);
      PIPE.fault(1'b1, 64'h1000_0104, 64'h1000_0100);
      #1;
      chk("flush", 1, flush_young);
      chk("redirect", 1, redirect);
      chk("vector", HANDLER_VEC, redirect_pc);
      rd(REG_RESTART);
      chk("restart_dly", 32'h1000_0100, d);
      rd(REG_STATUS);
      chk("exc_status", 32'h2, d & 32'h7);
      chk("exc_kernel", 1, kernel_mode);
      PIPE.ret();
      #1;
      chk("eret_pc", 64'h1000_0100, redirect_pc);
      rd(REG_STATUS);
      chk("eret_status", 32'h0, d & 32'h7);
      chk("eret_user", 0, kernel_mode);
      PIPE.fault(1'b0, 64'h2000_0200, 64'h0);
      rd(REG_RESTART);
      chk("restart_pc", 32'h2000_0200, d);
      PIPE.ret();
      PIPE.req_irq(8'h08);
      PIPE.run(64'h3000_0000);
      wr(REG_STATUS, 32'h0000_0011);
      irq_count(8);
      chk("irq_masked", 0, n);
      wr(REG_STATUS, 32'h0000_0811);
      n = 0;
      while (irq_take !== 1'b1)
      begin
         @(posedge clk);
         #1;
         n++;
         if (n > 8)
         begin
            err_total++;
            test_done();
         end
      end
      chk("irq_take", 1, irq_take);
      irq_count(8);
      chk("irq_in_exc", 0, n);
      rd(REG_RESTART);
      chk("restart_irq", 32'h3000_0000, d);
      PIPE.req_irq(8'h00);
      PIPE.ret();
      stl(1'b1, 5'h05, 5'h09, 1'b1);
      stl(1'b1, 5'h06, 5'h05, 1'b1);
      stl(1'b1, 5'h06, 5'h07, 1'b0);
      stl(1'b0, 5'h05, 5'h05, 1'b0);
      test_done();
   end
endmodule : tb_tlbex_top

// File: tb/tlbex_pipe_model.sv
`timescale 1ns/1ns
module tlbex_pipe_model
   import tlbex_pkg::*;
(
   input wire logic clk,
   output tlbex_stage_t stage_old,
   output tlbex_stage_t stage_young,
   output logic eret,
   output logic [7:0] irq,
   output logic src_busy,
   output logic [4:0] src_a,
   output logic [4:0] src_b,
   output logic [4:0] dst_pend
);
   initial
   begin
      stage_old = '0;
      stage_young = '0;
      eret = 1'b0;
      irq = 8'h00;
      src_busy = 1'b0;
      src_a = 5'h00;
      src_b = 5'h00;
      dst_pend = 5'h00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // both stages fault at once; the older one holds the earlier fetch
   task automatic fault(input logic dly, input logic [63:0] pc, input logic [63:0] bpc);
      @(posedge clk);
      stage_old <= '{1'b1, pc, dly, bpc, 3'h1};
      stage_young <= '{1'b1, pc + 64'h8, 1'b0, 64'h0, 3'h2};
      @(posedge clk);
      // released stages carry garbage, not the last value
      stage_old <= '{1'b0, ~pc, ~dly, ~bpc, 3'h0};
      stage_young <= '{1'b0, ~pc, 1'b1, pc, 3'h0};
   endtask : fault
   task automatic ret;
      @(posedge clk);
      eret <= 1'b1;
      @(posedge clk);
      eret <= 1'b0;
   endtask : ret
   // a plain instruction waits in the older stage; interrupts need one to attach to
   task automatic run(input logic [63:0] pc);
      @(posedge clk);
      stage_old <= '{1'b1, pc, 1'b0, 64'h0, 3'h0};
   endtask : run
   task automatic req_irq(input logic [7:0] v);
      @(posedge clk);
      irq <= v;
   endtask : req_irq
   task automatic src(input logic b, input logic [4:0] a, input logic [4:0] c);
      @(posedge clk);
      src_busy <= b;
      src_a <= a;
      src_b <= c;
      dst_pend <= 5'h05;
   endtask : src
endmodule : tlbex_pipe_model
